// ===== src/orp_defs.svh
`ifndef ORP_DEFS_SVH
`define ORP_DEFS_SVH

// clock period of mclk
`define ORP_CLK_NS 10
// least-time conversion, rounded up to whole cycles
`define ORP_CYC(ns) (((ns) + `ORP_CLK_NS - 1) / `ORP_CLK_NS)

// program pulse: nominal and allowed window
`define ORP_PW_NS 50000
`define ORP_PW_MIN_NS 47500
`define ORP_PW_MAX_NS 52500
`define ORP_PW_CYC (`ORP_PW_NS / `ORP_CLK_NS)
`define ORP_PW_MIN_CYC `ORP_CYC(`ORP_PW_MIN_NS)
`define ORP_PW_MAX_CYC (`ORP_PW_MAX_NS / `ORP_CLK_NS)

// setup, hold and recovery times
`define ORP_ALE_NS 500
`define ORP_LAH_NS 100
`define ORP_DS_NS 2000
`define ORP_DH_NS 2000
`define ORP_OES_NS 2000
`define ORP_VR_NS 2000
`define ORP_VCS_NS 2000
`define ORP_OE_NS 150
`define ORP_DFP_NS 130

// retry budget and last address
`define ORP_MAX_EXTRA 4'd10
`define ORP_LAST_ADDR 16'hffff
// upper address bit that picks the identity byte
`define ORP_ID_SEL_BIT 0

`endif

// ===== src/orp_pkg.sv
package orp_pkg;

  // level asked of the output-enable / program-supply pin
  typedef enum logic [1:0] {
    ORP_OPP_VIL = 2'h0,
    ORP_OPP_VIH = 2'h1,
    ORP_OPP_VPP = 2'h2
  } orp_opp_lvl_t;

  // level asked of the main supply
  typedef enum logic [1:0] {
    ORP_VCC_OFF = 2'h0,
    ORP_VCC_READ = 2'h1,
    ORP_VCC_PROG = 2'h2
  } orp_vcc_lvl_t;

  typedef enum logic [4:0] {
    ORP_PH_FIRST = 5'h01,
    ORP_PH_LOOP = 5'h02,
    ORP_PH_FINAL = 5'h04,
    ORP_PH_ID = 5'h08,
    ORP_PH_ABORT = 5'h10
  } orp_phase_t;

  // pins towards the memory
  typedef struct packed {
    logic ale;
    logic [7:0] muxed_addr_data_lines_o;
    logic muxed_addr_data_lines_oe;
    logic [7:0] upper_address_lines;
    orp_opp_lvl_t opp;
    orp_vcc_lvl_t vcc;
  } orp_pins_t;

  // outcome of a run
  typedef struct packed {
    logic busy;
    logic pass;
    logic fail;
    logic [3:0] extra_cnt;
    logic [15:0] fail_addr;
  } orp_status_t;

endpackage

// ===== src/orp_prog_seq.sv
`include "orp_defs.svh"

module orp_prog_seq #(
  parameter logic [15:0] PW_CYC = 16'(`ORP_PW_CYC), // program pulse length in cycles
  parameter logic [15:0] LAST_ADDR = `ORP_LAST_ADDR // last address programmed
) (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic start, // pulse: begin full programming run
  input wire logic id_req, // pulse: read identity byte
  input wire logic id_sel, // identity byte select
  output logic [15:0] src_addr, // address of wanted source byte
  input wire logic [7:0] src_data, // source byte for src_addr
  input wire logic [7:0] muxed_addr_data_lines_i, // bus level read back
  output orp_pkg::orp_pins_t pins, // registered pin drive
  output orp_pkg::orp_status_t status, // run outcome
  output logic done, // pulse: run or identity read ended
  output logic [7:0] id_code, // last identity byte read
  output logic id_valid // pulse: id_code updated
);
  import orp_pkg::*;

  typedef enum logic [13:0] {
    S_IDLE = 14'h0001,
    S_VCC = 14'h0002,
    S_VPP = 14'h0004,
    S_ALE_HI = 14'h0008,
    S_ALE_LO = 14'h0010,
    S_DSET = 14'h0020,
    S_PULSE = 14'h0040,
    S_DHOLD = 14'h0080,
    S_VPP_DN = 14'h0100,
    S_OE_ON = 14'h0200,
    S_OE_OFF = 14'h0400,
    S_VPP_OFF = 14'h0800,
    S_VCC_DN = 14'h1000,
    S_VPP_UP = 14'h2000
  } orp_state_t;

  orp_state_t state_q, state_d;
  orp_phase_t phase_q;
  logic [15:0] tmr_q;
  logic [15:0] addr_q;
  logic [3:0] extra_q;
  logic pend_q;
  logic pass_q, fail_q;
  logic [15:0] fail_addr_q;
  logic [7:0] id_q;
  logic done_q, idv_q;
  logic sel_q;
  logic [7:0] rd_q;
  orp_pins_t pins_q, pins_d;
  logic fin, match, last;

  // cycles to spend in a state, least times rounded up
  function automatic logic [15:0] wait_of(input orp_state_t s);
    case (s)
      S_VCC, S_VCC_DN: wait_of = 16'(`ORP_CYC(`ORP_VCS_NS));
      S_VPP, S_VPP_UP: wait_of = 16'(`ORP_CYC(`ORP_OES_NS));
      S_ALE_HI: wait_of = 16'(`ORP_CYC(`ORP_ALE_NS));
      S_ALE_LO: wait_of = 16'(`ORP_CYC(`ORP_LAH_NS));
      S_DSET: wait_of = 16'(`ORP_CYC(`ORP_DS_NS));
      S_PULSE: wait_of = PW_CYC;
      S_DHOLD: wait_of = 16'(`ORP_CYC(`ORP_DH_NS));
      S_VPP_DN, S_VPP_OFF: wait_of = 16'(`ORP_CYC(`ORP_VR_NS));
      // one extra cycle covers the pin register lag
      S_OE_ON: wait_of = 16'(`ORP_CYC(`ORP_OE_NS) + 1);
      S_OE_OFF: wait_of = 16'(`ORP_CYC(`ORP_DFP_NS));
      default: wait_of = 16'h0001;
    endcase
  endfunction

  assign fin = (tmr_q == 16'h0000);
  // compare the byte caught while the device drove the bus, not the floating bus
  assign match = (rd_q == src_data);
  assign last = (addr_q == LAST_ADDR);

  // sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (start || id_req) state_d = S_VCC;
      S_VCC: if (fin) state_d = (phase_q == ORP_PH_ID) ? S_ALE_HI : S_VPP;
      S_VPP, S_VPP_UP: if (fin) state_d = S_ALE_HI;
      S_ALE_HI: if (fin) state_d = S_ALE_LO;
      S_ALE_LO: begin
        if (fin && (phase_q == ORP_PH_FIRST || (phase_q == ORP_PH_LOOP && pend_q))) begin
          state_d = S_DSET;
        end else if (fin) begin
          state_d = (phase_q == ORP_PH_LOOP) ? S_VPP_DN : S_OE_ON;
        end
      end
      S_DSET: if (fin) state_d = S_PULSE;
      S_PULSE: if (fin) state_d = S_DHOLD;
      S_DHOLD: if (fin) state_d = (phase_q == ORP_PH_FIRST) ? S_ALE_HI : S_VPP_DN;
      S_VPP_DN: if (fin) state_d = S_OE_ON;
      S_OE_ON: if (fin) state_d = S_OE_OFF;
      S_OE_OFF: begin
        if (fin) begin
          case (phase_q)
            ORP_PH_ID: state_d = S_IDLE;
            ORP_PH_LOOP: begin
              state_d = (match ? last : extra_q == `ORP_MAX_EXTRA) ? S_VPP_OFF : S_VPP_UP;
            end
            ORP_PH_FINAL: state_d = (!match || last) ? S_IDLE : S_ALE_HI;
            default: state_d = S_IDLE;
          endcase
        end
      end
      S_VPP_OFF: if (fin) state_d = S_VCC_DN;
      S_VCC_DN: if (fin) state_d = (phase_q == ORP_PH_FINAL) ? S_ALE_HI : S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // dwell timer, reloaded on every state change
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= 16'h0000;
    end else if (state_d != state_q) begin
      tmr_q <= wait_of(state_d) - 16'h0001;
    end else if (!fin) begin
      tmr_q <= tmr_q - 16'h0001;
    end
  end

  // phase, address and retry bookkeeping
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= ORP_PH_FIRST;
      addr_q <= 16'h0000;
      extra_q <= 4'h0;
      pend_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      if (state_q == S_IDLE && start) begin
        phase_q <= ORP_PH_FIRST;
        addr_q <= 16'h0000;
        extra_q <= 4'h0;
        pend_q <= 1'b0;
      end else if (state_q == S_IDLE && id_req) begin
        phase_q <= ORP_PH_ID;
        sel_q <= id_sel;
      end
      if (state_q == S_DHOLD && fin && phase_q == ORP_PH_FIRST) begin
        if (last) begin
          phase_q <= ORP_PH_LOOP;
          addr_q <= 16'h0000;
        end else begin
          addr_q <= addr_q + 16'h0001;
        end
      end
      if (state_q == S_DHOLD && fin) pend_q <= 1'b0;
      if (state_q == S_OE_OFF && fin && phase_q == ORP_PH_LOOP) begin
        if (match) begin
          extra_q <= 4'h0;
          addr_q <= last ? 16'h0000 : addr_q + 16'h0001;
          if (last) begin
            phase_q <= ORP_PH_FINAL;
          end
        end else if (extra_q == `ORP_MAX_EXTRA) begin
          phase_q <= ORP_PH_ABORT;
        end else begin
          extra_q <= extra_q + 4'h1;
          pend_q <= 1'b1;
        end
      end
      if (state_q == S_OE_OFF && fin && phase_q == ORP_PH_FINAL && match && !last) begin
        addr_q <= addr_q + 16'h0001;
      end
    end
  end

  // sticky outcome; pass and fail cleared by reset or a new run, fail_addr_q only by reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      fail_addr_q <= 16'h0000;
    end else if (state_q == S_IDLE && start) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (state_q == S_OE_OFF && fin) begin
      if (!match && (phase_q == ORP_PH_FINAL ||
          (phase_q == ORP_PH_LOOP && extra_q == `ORP_MAX_EXTRA))) begin
        fail_q <= 1'b1;
        fail_addr_q <= addr_q;
      end else if (match && last && phase_q == ORP_PH_FINAL) begin
        pass_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      id_q <= 8'h00;
      rd_q <= 8'h00;
      idv_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      // sample at the end of the enable window; after it the bus floats
      if (state_q == S_OE_ON && fin) rd_q <= muxed_addr_data_lines_i;
      idv_q <= state_q == S_OE_OFF && fin && phase_q == ORP_PH_ID;
      done_q <= state_q != S_IDLE && state_d == S_IDLE;
      if (state_q == S_OE_OFF && fin && phase_q == ORP_PH_ID) id_q <= rd_q;
    end
  end

  // pin levels per state, registered below
  always_comb begin
    pins_d = '0;
    pins_d.opp = ORP_OPP_VIH;
    pins_d.vcc = ORP_VCC_OFF;
    pins_d.upper_address_lines = addr_q[15:8];
    pins_d.muxed_addr_data_lines_o = addr_q[7:0];
    if (phase_q == ORP_PH_ID) begin
      pins_d.upper_address_lines = 8'h00;
      pins_d.upper_address_lines[`ORP_ID_SEL_BIT] = sel_q;
      pins_d.muxed_addr_data_lines_o = 8'h00;
    end
    if (state_q != S_IDLE) begin
      pins_d.vcc = (phase_q == ORP_PH_FIRST || phase_q == ORP_PH_LOOP ||
                    state_q == S_VPP_OFF) ? ORP_VCC_PROG : ORP_VCC_READ;
      if (phase_q == ORP_PH_ABORT && state_q == S_VCC_DN) pins_d.vcc = ORP_VCC_OFF;
    end
    case (state_q)
      S_VPP, S_VPP_UP, S_DSET, S_PULSE, S_DHOLD: pins_d.opp = ORP_OPP_VPP;
      S_ALE_HI, S_ALE_LO: begin
        pins_d.opp = (phase_q == ORP_PH_FIRST || phase_q == ORP_PH_LOOP) ?
                     ORP_OPP_VPP : ORP_OPP_VIH;
      end
      S_OE_ON: pins_d.opp = ORP_OPP_VIL;
      default: pins_d.opp = ORP_OPP_VIH;
    endcase
    pins_d.ale = (state_q == S_ALE_HI || state_q == S_PULSE);
    pins_d.muxed_addr_data_lines_oe = (state_q == S_ALE_HI || state_q == S_ALE_LO ||
                                       state_q == S_DSET || state_q == S_PULSE ||
                                       state_q == S_DHOLD);
    if (state_q == S_DSET || state_q == S_PULSE || state_q == S_DHOLD)
      pins_d.muxed_addr_data_lines_o = src_data;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pins_q <= '{ale: 1'b0, muxed_addr_data_lines_o: 8'h00,
                  muxed_addr_data_lines_oe: 1'b0, upper_address_lines: 8'h00,
                  opp: ORP_OPP_VIH, vcc: ORP_VCC_OFF};
    end else begin
      pins_q <= pins_d;
    end
  end

  assign pins = pins_q;
  assign src_addr = addr_q;
  assign status = '{busy: state_q != S_IDLE, pass: pass_q, fail: fail_q,
                    extra_cnt: extra_q, fail_addr: fail_addr_q};
  assign done = done_q;
  assign id_code = id_q;
  assign id_valid = idv_q;

endmodule // orp_prog_seq

// ===== testbench/orp_prog_seq_checker.sv
module orp_prog_seq_checker
  import orp_pkg::*;
#(
  parameter logic [15:0] PW_CYC = 16'd80 // program pulse cycles
) (
  input wire logic mclk, // clock
  input wire logic rstn, // reset, low
  input wire logic start, // run request
  input wire logic id_req, // id request
  input wire logic id_sel, // id select
  input wire logic [15:0] src_addr, // source address
  input wire logic [7:0] src_data, // source byte
  input wire logic [7:0] muxed_addr_data_lines_i, // bus read back
  input wire orp_pins_t pins, // pin drive
  input wire orp_status_t status, // outcome
  input wire logic done, // end pulse
  input wire logic [7:0] id_code, // id byte
  input wire logic id_valid // id update
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hi_q;
  logic [15:0] vcc_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // strobe length and supply dwell, so widths can be checked exactly
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hi_q <= 16'h0;
      vcc_q <= 16'h0;
    end else begin
      hi_q <= pins.ale ? hi_q + 16'h1 : 16'h0;
      vcc_q <= (pins.vcc == ORP_VCC_PROG) ? vcc_q + 16'h1 : 16'h0;
    end
  end
  a_vpp_needs_vcc: assert property (
    pins.opp == ORP_OPP_VPP |-> pins.vcc == ORP_VCC_PROG) else $error("vpp without vcc");
  a_vcc_setup: assert property (
    $rose(pins.opp == ORP_OPP_VPP) |-> vcc_q >= 16'd200) else $error("vcc setup short");
  a_pulse_len: assert property (
    $fell(pins.ale) && pins.opp == ORP_OPP_VPP && hi_q > 16'd50 |-> hi_q == PW_CYC)
    else $error("pulse width wrong");
  a_pulse_data: assert property (
    pins.ale && pins.opp == ORP_OPP_VPP && hi_q > 16'd50 |->
    pins.muxed_addr_data_lines_oe && $stable(pins.muxed_addr_data_lines_o))
    else $error("data moved in pulse");
  a_first_addr: assert property (
    $rose(pins.vcc == ORP_VCC_PROG) |-> src_addr == 16'h0) else $error("not lowest address");
  a_read_released: assert property (
    pins.opp == ORP_OPP_VIL |-> !pins.muxed_addr_data_lines_oe) else $error("bus fight");
  a_extra_bound: assert property (
    status.extra_cnt <= 4'd10) else $error("too many extra pulses");
  a_flags_apart: assert property (
    !(status.pass && status.fail)) else $error("pass and fail together");
  a_read_supply: assert property (
    $rose(pins.vcc == ORP_VCC_READ) |-> pins.opp == ORP_OPP_VIH) else $error("vpp at read");
endmodule // orp_prog_seq_checker

bind orp_prog_seq orp_prog_seq_checker #(.PW_CYC(PW_CYC)) u_chk (.mclk(mclk), .rstn(rstn),
  .start(start), .id_req(id_req), .id_sel(id_sel), .src_addr(src_addr),
  .src_data(src_data), .muxed_addr_data_lines_i(muxed_addr_data_lines_i), .pins(pins),
  .status(status), .done(done), .id_code(id_code), .id_valid(id_valid));

// ===== testbench/orp_otp_model.sv
module orp_otp_model
  import orp_pkg::*;
#(
  parameter logic [15:0] PW_CYC = 16'd80, // nominal pulse
  parameter logic [7:0] ID_MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0] ID_PART = 8'ha7 // arbitrary value
) (
  input wire logic mclk, // sample clock
  input wire logic rstn, // fits a blank part
  input wire orp_pins_t pins, // pins from host
  input wire logic id_mode, // identity lines selected
  input wire logic [15:0] hard_addr, // stubborn byte
  input wire logic [4:0] hard_n, // pulses it needs
  input wire logic [3:0] rd_lag, // read access delay
  output logic [7:0] dout, // read data
  output logic den // device drives bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:3];
  logic [4:0] npulse [0:3];
  logic [15:0] a_q;
  logic [15:0] hi_q;
  logic [3:0] rdc_q;
  logic [7:0] rd;
  int viol;
  // latch on short strobes, program on long ones at high voltage
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      foreach (mem[i]) begin
        mem[i] = 8'hff;
        npulse[i] = 5'h0;
      end
      a_q = 16'h0;
      hi_q = 16'h0;
      rdc_q = 4'h0;
      viol = 0;
    end else begin
      // high voltage only over program supply
      if (pins.opp == ORP_OPP_VPP && pins.vcc != ORP_VCC_PROG) viol++;
      rdc_q = den ? rdc_q + 4'(rdc_q != 4'hf) : 4'h0;
      if (pins.ale) begin
        hi_q++;
      end else if (hi_q != 16'h0) begin
        // pulse must sit in the width window
        if (hi_q > 16'd50) begin
          if (hi_q < PW_CYC * 95 / 100 || hi_q > PW_CYC * 105 / 100) viol++;
          if (pins.opp != ORP_OPP_VPP) viol++;
          npulse[a_q[1:0]]++;
          if (npulse[a_q[1:0]] >= (a_q == hard_addr ? hard_n : 5'h1)) begin
            mem[a_q[1:0]] = pins.muxed_addr_data_lines_o;
          end
        end else begin
          a_q = {pins.upper_address_lines, pins.muxed_addr_data_lines_o};
        end
        hi_q = 16'h0;
      end
    end
  end
  // identity byte picked by the upper line; slow reads show junk first
  assign rd = id_mode ? (pins.upper_address_lines[0] ? ID_PART : ID_MAKER) : mem[a_q[1:0]];
  assign den = pins.opp == ORP_OPP_VIL && pins.vcc != ORP_VCC_OFF;
  assign dout = (rdc_q < rd_lag) ? ~rd : rd;
endmodule // orp_otp_model

// ===== testbench/orp_prog_seq_bench.sv
module orp_prog_seq_bench
  import orp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] PW = 16'd80;
  logic mclk = 0, rstn = 0, start = 0, id_req = 0, id_sel = 0, id_mode = 0;
  logic den, done, id_valid;
  logic [7:0] src [0:3];
  logic [7:0] bus, dout, id_code, bus_q = 8'h0;
  logic [15:0] src_addr, hard_addr = 16'h0;
  logic [4:0] hard_n = 5'h1;
  logic [3:0] lag = 4'h0;
  wire logic [7:0] src_data;
  orp_pins_t pins;
  orp_status_t status;
  int num_errors = 0, n_compared = 0, seed = 25, cyc = 0;
  always #5 mclk = ~mclk;
  // a released bus shows the inverse of its last level
  assign bus = pins.muxed_addr_data_lines_oe ? pins.muxed_addr_data_lines_o : den ? dout : ~bus_q;
  assign src_data = src[src_addr[1:0]];
  always @(posedge mclk) bus_q <= bus;
  orp_prog_seq #(.PW_CYC(PW), .LAST_ADDR(16'h3)) DUT (.mclk(mclk), .rstn(rstn),
    .start(start), .id_req(id_req), .id_sel(id_sel), .src_addr(src_addr),
    .src_data(src_data), .muxed_addr_data_lines_i(bus), .pins(pins), .status(status),
    .done(done), .id_code(id_code), .id_valid(id_valid));
  orp_otp_model #(.PW_CYC(PW)) DEV (.mclk(mclk), .rstn(rstn), .pins(pins),
    .id_mode(id_mode), .hard_addr(hard_addr), .hard_n(hard_n), .rd_lag(lag),
    .dout(dout), .den(den));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // pulses a byte should have seen: one, or its need capped at eleven
  function automatic logic [15:0] exp_pulses(input int i);
    if (i != hard_addr) return 16'h1;
    return (hard_n > 5'd11) ? 16'd11 : 16'(hard_n);
  endfunction
  task pulse_cmd(input logic run, input logic sel);
    @(posedge mclk);
    #1 start = run;
    id_req = !run;
    id_sel = sel;
    @(posedge mclk);
    #1 start = 0;
    id_req = 0;
  endtask
  task wait_done;
    for (int k = 0; k < 30000 && done !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task run_part(input logic [4:0] hn, input logic ok);
    rstn = 0;
    repeat (16) @(posedge mclk);
    #1 rstn = 1;
    id_mode = 0;
    hard_n = hn;
    hard_addr = 16'({$random(seed)} % 4);
    lag = 4'({$random(seed)} % 15);
    foreach (src[i]) src[i] = 8'($random(seed)) & 8'hfe;
    pulse_cmd(1, 0);
    repeat (100) @(posedge mclk);
    chk(status.busy, 1'b1);
    // a request while busy must leave no trace
    pulse_cmd(0, 1);
    wait_done;
    chk(done, 1'b1);
    chk(status.busy, 1'b0);
    chk(id_valid, 1'b0);
    chk(id_code, 8'h00);
    chk(status.pass, ok);
    chk(status.fail, !ok);
    chk(16'(DEV.viol), 16'h0);
    for (int i = 0; i < 4; i++) begin
      chk(16'(DEV.npulse[i]), exp_pulses(i));
      if (ok || i != hard_addr) chk(DEV.mem[i], src[i]);
    end
    if (!ok) begin
      chk(status.fail_addr, hard_addr);
      chk(status.extra_cnt, 4'd10);
      chk(pins.vcc, ORP_VCC_OFF);
    end
    $display("test run: need %0d pulses at %0d, lag %0d", hn, hard_addr, lag);
  endtask
  // hang guard: the longest run takes about fifteen thousand cycles, all tests under fifty
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      $display("mismatch at %0t: run hung", $time);
      final_report;
    end
  end
  initial begin
    foreach (src[i]) src[i] = 8'h0;
    repeat (16) @(posedge mclk);
    #1 rstn = 1;
    chk(pins.opp, ORP_OPP_VIH);
    chk(pins.vcc, ORP_VCC_OFF);
    chk(pins.ale, 1'b0);
    chk(status.busy, 1'b0);
    for (int s = 0; s < 2; s++) begin
      id_mode = 1;
      pulse_cmd(0, s[0]);
      wait_done;
      chk(id_valid, 1'b1);
      chk(id_code, s[0] ? 8'ha7 : 8'h5a);
      $display("test identity %0d", s);
    end
    run_part(5'd1, 1'b1);
    run_part(5'd4, 1'b1);
    run_part(5'd11, 1'b1);
    run_part(5'd12, 1'b0);
    final_report;
  end
endmodule // orp_prog_seq_bench
